// ==== scr_map.svh ====
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// ------------------------------------------------------------
// Coprocessor register numbers
// ------------------------------------------------------------
`define SCR_CRN_CACHE_INFO 4'h0
`define SCR_CRN_CONTROL 4'h1

// ------------------------------------------------------------
// Cache information field positions
// ------------------------------------------------------------
`define SCR_CI_LINE_LSB 0
`define SCR_CI_MULT_BIT 2
`define SCR_CI_ASSOC_LSB 3
`define SCR_CI_SIZE_LSB 6

// ------------------------------------------------------------
// Control register field positions and masks
// ------------------------------------------------------------
`define SCR_CTL_MMU 0
`define SCR_CTL_ALIGN 1
`define SCR_CTL_DCACHE 2
`define SCR_CTL_WBUF 3
`define SCR_CTL_ENDIAN 7
`define SCR_CTL_SYSP 8
`define SCR_CTL_ROMP 9
`define SCR_CTL_ICACHE 12
`define SCR_CTL_VECT 13
`define SCR_CTL_WR_MASK 32'h0000338F
`define SCR_CTL_ONES_MASK 32'h00000070
`define SCR_CTL_RESET 32'h00000000

// ------------------------------------------------------------
// Vector bases and cache size units
// ------------------------------------------------------------
`define SCR_VEC_LOW 32'h00000000
`define SCR_VEC_HIGH 32'hFFFF0000
`define SCR_LINE_BASE_BYTES 8
`define SCR_SIZE_BASE_BYTES 512

`endif

// ==== scr_pkg.sv ====
package scr_pkg;

    typedef logic [31:0] scr_word_t;

    typedef enum logic [1:0]
    {
        SCR_BYTE,
        SCR_HALF,
        SCR_WORD
    } scr_acc_size_e;

endpackage

// ==== scr_align_if.sv ====
`timescale 1ns/10ps

interface scr_align_if;
    logic check_en;
    logic valid;
    scr_pkg::scr_acc_size_e size;
    logic [1:0] addr_lo;
    logic fault;

    modport ctl
    (
        output check_en,
        output valid,
        output size,
        output addr_lo,
        input fault
    );

    modport chk
    (
        input check_en,
        input valid,
        input size,
        input addr_lo,
        output fault
    );
endinterface

// ==== scr_align_chk.sv ====
`timescale 1ns/10ps

module scr_align_chk
(
    input wire logic clk,
    input wire logic sys_rst,
    scr_align_if.chk acc
);

    // ------------------------------------------------------------
    // Misalignment decode
    // ------------------------------------------------------------
    // Bytes never fault; a size code outside the three legal ones is
    // treated as a word so that a corrupted request still gets checked.
    function automatic logic misaligned(scr_pkg::scr_acc_size_e sz,
                                        logic [1:0] lo);
        logic bad;
        bad = 1'b0;
        unique case (sz)
            scr_pkg::SCR_BYTE: bad = 1'b0;
            scr_pkg::SCR_HALF: bad = lo[0];
            default: bad = |lo;
        endcase
        return bad;
    endfunction

    logic fault_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            fault_reg <= 1'b0;
        else
            fault_reg <= acc.valid && acc.check_en &&
                         misaligned(acc.size, acc.addr_lo);
    end

    assign acc.fault = fault_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence half_odd_s;
        acc.valid && acc.check_en && acc.size == scr_pkg::SCR_HALF &&
        acc.addr_lo[0];
    endsequence

    align_fault_a: assert property (@(posedge clk) disable iff (sys_rst)
        half_odd_s |=> acc.fault)
        else $error("odd half-word did not raise an alignment fault");

    align_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        !acc.check_en |=> !acc.fault)
        else $error("alignment fault raised while checking is disabled");

    align_byte_a: assert property (@(posedge clk) disable iff (sys_rst)
        (acc.valid && acc.size == scr_pkg::SCR_BYTE) |=> !acc.fault)
        else $error("byte access raised an alignment fault");

endmodule

// ==== scr_sysctl.sv ====
`timescale 1ns/10ps
`include "scr_map.svh"

module scr_sysctl
#(
    parameter logic [2:0] ICACHE_SIZE_CODE = 3'h0,
    parameter logic [2:0] ICACHE_ASSOC_CODE = 3'h0,
    parameter logic ICACHE_MULT = 1'b0,
    parameter logic [1:0] ICACHE_LINE_CODE = 2'h0
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic high_vectors_pin,
    input wire logic cp_valid,
    input wire logic cp_write,
    input wire logic [3:0] cp_reg,
    input wire logic [3:0] secondary_register_field,
    input wire logic [2:0] cp_opcode2,
    input wire scr_pkg::scr_word_t cp_wdata,
    output scr_pkg::scr_word_t cp_rdata,
    output logic cp_rvalid,
    output logic cp_undef,
    input wire logic dacc_valid,
    input wire scr_pkg::scr_acc_size_e dacc_size,
    input wire logic [1:0] dacc_addr_lo,
    output logic align_fault,
    output scr_pkg::scr_word_t vector_base,
    output logic icache_en,
    output logic dcache_en,
    output logic wbuf_en,
    output logic rom_prot,
    output logic sys_prot,
    output logic align_chk_en,
    output logic mmu_en,
    output logic icache_present,
    output logic [6:0] icache_line_bytes,
    output logic [16:0] icache_size_bytes,
    output logic [7:0] icache_ways
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic scr_pkg::scr_word_t ctl_image(scr_pkg::scr_word_t s);
        return (s & `SCR_CTL_WR_MASK) | `SCR_CTL_ONES_MASK;
    endfunction

    function automatic logic [6:0] line_bytes(logic [1:0] code);
        return 7'(`SCR_LINE_BASE_BYTES << code);
    endfunction

    // A 3/2 multiplier on a one-way base means there is no cache at all.
    function automatic logic [16:0] size_bytes(logic [2:0] code,
                                               logic mult);
        logic [16:0] base;
        base = 17'(`SCR_SIZE_BASE_BYTES << code);
        return mult ? 17'(base + (base >> 1)) : base;
    endfunction

    function automatic logic [7:0] ways(logic [2:0] code, logic mult);
        logic [7:0] base;
        base = 8'(1 << code);
        if (!mult)
            return base;
        if (code == 3'h0)
            return 8'h00;
        return 8'(base + (base >> 1));
    endfunction

    // ------------------------------------------------------------
    // High vectors pin synchroniser
    // ------------------------------------------------------------
    logic hv_s1_reg;
    logic hv_s2_reg;
    logic hv_s3_reg;
    logic hv_level_reg;

    // The chain free-runs through reset, and a new level counts only once
    // the last two stages agree; reset must therefore last five cycles.
    always_ff @(posedge clk)
    begin
        hv_s1_reg <= high_vectors_pin;
        hv_s2_reg <= hv_s1_reg;
        hv_s3_reg <= hv_s2_reg;
        if (hv_s2_reg == hv_s3_reg)
            hv_level_reg <= hv_s3_reg;
    end

    // ------------------------------------------------------------
    // Transfer decode
    // ------------------------------------------------------------
    logic sel_ctl;
    logic sel_ci;
    scr_pkg::scr_word_t ci_word;

    // Secondary register and opcode fields are deliberately not decoded.
    assign sel_ctl = cp_reg == `SCR_CRN_CONTROL;
    assign sel_ci = cp_reg == `SCR_CRN_CACHE_INFO;

    assign ci_word = (32'(ICACHE_SIZE_CODE) << `SCR_CI_SIZE_LSB) |
                     (32'(ICACHE_ASSOC_CODE) << `SCR_CI_ASSOC_LSB) |
                     (32'(ICACHE_MULT) << `SCR_CI_MULT_BIT) |
                     (32'(ICACHE_LINE_CODE) << `SCR_CI_LINE_LSB);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    scr_pkg::scr_word_t ctl_reg;
    scr_pkg::scr_word_t ctl_next;

    always_comb
    begin
        ctl_next = ctl_reg;
        if (cp_valid && cp_write && sel_ctl)
            ctl_next = cp_wdata & `SCR_CTL_WR_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctl_reg <= `SCR_CTL_RESET;
            ctl_reg[`SCR_CTL_VECT] <= hv_level_reg;
        end
        else
            ctl_reg <= ctl_next;
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    scr_pkg::scr_word_t rdata_reg;
    logic rvalid_reg;
    logic undef_reg;

    // Bits 31..15 read as zero; software must not rely on that.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rdata_reg <= 32'h00000000;
            rvalid_reg <= 1'b0;
            undef_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= cp_valid && !cp_write;
            undef_reg <= cp_valid && !sel_ctl && !sel_ci;
            if (cp_valid && !cp_write)
            begin
                if (sel_ctl)
                    rdata_reg <= ctl_image(ctl_reg);
                else if (sel_ci)
                    rdata_reg <= ci_word;
                else
                    rdata_reg <= 32'h00000000;
            end
        end
    end

    assign cp_rdata = rdata_reg;
    assign cp_rvalid = rvalid_reg;
    assign cp_undef = undef_reg;

    // ------------------------------------------------------------
    // Cache information decode
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            icache_present <= 1'b0;
            icache_line_bytes <= 7'h00;
            icache_size_bytes <= 17'h00000;
            icache_ways <= 8'h00;
        end
        else
        begin
            icache_present <= !(ICACHE_MULT && ICACHE_ASSOC_CODE == 3'h0);
            icache_line_bytes <= line_bytes(ICACHE_LINE_CODE);
            icache_size_bytes <= size_bytes(ICACHE_SIZE_CODE, ICACHE_MULT);
            icache_ways <= ways(ICACHE_ASSOC_CODE, ICACHE_MULT);
        end
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    assign vector_base = ctl_reg[`SCR_CTL_VECT] ? `SCR_VEC_HIGH
                                                : `SCR_VEC_LOW;
    assign icache_en = ctl_reg[`SCR_CTL_ICACHE];
    assign mmu_en = ctl_reg[`SCR_CTL_MMU];
    // Gating here keeps invalid cache states away from the memory side.
    assign dcache_en = ctl_reg[`SCR_CTL_DCACHE] && mmu_en;
    assign wbuf_en = ctl_reg[`SCR_CTL_WBUF] && mmu_en;
    assign rom_prot = ctl_reg[`SCR_CTL_ROMP];
    assign sys_prot = ctl_reg[`SCR_CTL_SYSP];
    assign align_chk_en = ctl_reg[`SCR_CTL_ALIGN];

    // ------------------------------------------------------------
    // Alignment checker
    // ------------------------------------------------------------
    scr_align_if acc_if ();

    assign acc_if.check_en = align_chk_en;
    assign acc_if.valid = dacc_valid;
    assign acc_if.size = dacc_size;
    assign acc_if.addr_lo = dacc_addr_lo;
    assign align_fault = acc_if.fault;

    scr_align_chk u_align
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .acc(acc_if)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence ctl_write_s;
        cp_valid && cp_write && sel_ctl;
    endsequence

    sequence ctl_read_s;
        cp_valid && !cp_write && sel_ctl;
    endsequence

    ctl_write_take_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctl_write_s ##1 (cp_valid && !cp_write && sel_ctl) |=>
        cp_rdata == ctl_image($past(cp_wdata, 2)))
        else $error("control read does not return the last write");

    ctl_fixed_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctl_read_s |=> cp_rvalid && cp_rdata[14] == 1'b0 &&
        cp_rdata[11:10] == 2'b00 && cp_rdata[31:15] == 17'h00000)
        else $error("control read shows nonzero in fixed-zero bits");

    ctl_ones_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctl_read_s |=> cp_rdata[6:4] == 3'b111)
        else $error("control read bits 6..4 not all ones");

    reset_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> (ctl_reg & ~(32'h1 << `SCR_CTL_VECT)) == 32'h0)
        else $error("writable control bits not cleared by reset");

    vector_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctl_write_s |=> vector_base ==
        ($past(cp_wdata[`SCR_CTL_VECT]) ? 32'hFFFF0000 : 32'h0))
        else $error("vector base does not follow the select bit");

    dcache_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        !mmu_en |-> !dcache_en && !wbuf_en)
        else $error("data cache or write buffer active with MMU off");

    icache_indep_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctl_write_s |=> icache_en == $past(cp_wdata[`SCR_CTL_ICACHE]))
        else $error("instruction cache enable does not follow a write");

    prot_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctl_write_s |=> rom_prot == $past(cp_wdata[9]) &&
        sys_prot == $past(cp_wdata[8]))
        else $error("protection bits not passed to the MMU");

    mmu_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctl_write_s |=> mmu_en == $past(cp_wdata[0]))
        else $error("MMU enable does not follow a write");

    line_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |=> icache_line_bytes == (7'd8 << ICACHE_LINE_CODE))
        else $error("instruction cache line length misreported");

    no_cache_a: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |=> icache_present ==
        !(ICACHE_MULT && ICACHE_ASSOC_CODE == 3'h0))
        else $error("instruction cache presence misreported");

endmodule

// ==== scr_core_model.sv ====
`timescale 1ns/10ps

// ------------------------------------------------------------
// Core side of the coprocessor transfer port
// ------------------------------------------------------------
module scr_core_model
(
    input wire logic clk,
    output logic cp_valid,
    output logic cp_write,
    output logic [3:0] cp_reg,
    output logic [3:0] secondary_register_field,
    output logic [2:0] cp_opcode2,
    output scr_pkg::scr_word_t cp_wdata,
    input wire scr_pkg::scr_word_t cp_rdata,
    input wire logic cp_rvalid,
    input wire logic cp_undef
);
    initial
    begin
        cp_valid = 1'b0;
        cp_write = 1'b0;
        cp_reg = 4'h0;
        secondary_register_field = 4'h0;
        cp_opcode2 = 3'h0;
        cp_wdata = 32'h00000000;
    end

    // Entered at a falling edge; returns one falling edge after the
    // rising edge that takes the request, with the request still up.
    task automatic put(input logic wr, input logic [3:0] rn,
        input scr_pkg::scr_word_t d);
        begin
            cp_valid = 1'b1;
            cp_write = wr;
            cp_reg = rn;
            secondary_register_field = 4'h0;
            cp_opcode2 = 3'h0;
            cp_wdata = d & 32'h00007F7F;
            @(negedge clk);
        end
    endtask

    task automatic write(input logic [3:0] rn, input scr_pkg::scr_word_t d);
        begin
            put(1'b1, rn, d);
        end
    endtask

    // The answer has a fixed latency of one cycle, so no wait is needed.
    task automatic read(input logic [3:0] rn, output scr_pkg::scr_word_t d,
        output logic ok, output logic und);
        begin
            put(1'b0, rn, 32'h00000000);
            ok = cp_rvalid;
            und = cp_undef;
            d = cp_rdata & 32'h00007FFF;
        end
    endtask

    // Data is scrambled when released so a stale value cannot pass.
    task automatic idle;
        begin
            cp_valid = 1'b0;
            cp_wdata = ~cp_wdata;
            @(negedge clk);
        end
    endtask

    task automatic rmw(input scr_pkg::scr_word_t set_m,
        input scr_pkg::scr_word_t clr_m);
        scr_pkg::scr_word_t v;
        logic ok;
        logic und;
        begin
            read(4'h1, v, ok, und);
            write(4'h1, (v & ~clr_m) | set_m);
        end
    endtask
endmodule

// ==== cpu_system_control_regs_bench.sv ====
`timescale 1ns/10ps

module cpu_system_control_regs_bench;
    typedef struct {
        scr_pkg::scr_word_t wr;
        scr_pkg::scr_word_t rd;
        logic [7:0] en;
    } scr_row_s;

    logic clk;
    logic sys_rst;
    logic high_vectors_pin;
    logic cp_valid;
    logic cp_write;
    logic [3:0] cp_reg;
    logic [3:0] secondary_register_field;
    logic [2:0] cp_opcode2;
    scr_pkg::scr_word_t cp_wdata;
    scr_pkg::scr_word_t cp_rdata;
    logic cp_rvalid;
    logic cp_undef;
    logic dacc_valid;
    scr_pkg::scr_acc_size_e dacc_size;
    logic [1:0] dacc_addr_lo;
    logic align_fault;
    scr_pkg::scr_word_t vector_base;
    logic icache_en;
    logic dcache_en;
    logic wbuf_en;
    logic rom_prot;
    logic sys_prot;
    logic align_chk_en;
    logic mmu_en;
    logic icache_present;
    logic [6:0] icache_line_bytes;
    logic [16:0] icache_size_bytes;
    logic [7:0] icache_ways;
    int fails = 0;
    int n_tests = 0;
    logic exp_f;

    // Row enables: vector select, icache, rom, sys, align, mmu, dcache, wbuf.
    scr_row_s rows [5] = '{
        '{32'h00007C7F, 32'h0000307F, 8'hCF},
        '{32'h0000130C, 32'h0000137C, 8'h70},
        '{32'h00000005, 32'h00000075, 8'h06},
        '{32'h00000009, 32'h00000079, 8'h05},
        '{32'h00000000, 32'h00000070, 8'h00}
    };

    scr_sysctl #(
        .ICACHE_SIZE_CODE(3'h2),
        .ICACHE_ASSOC_CODE(3'h1),
        .ICACHE_MULT(1'b1),
        .ICACHE_LINE_CODE(2'h1)
    ) uut (
        .clk(clk),
        .sys_rst(sys_rst),
        .high_vectors_pin(high_vectors_pin),
        .cp_valid(cp_valid),
        .cp_write(cp_write),
        .cp_reg(cp_reg),
        .secondary_register_field(secondary_register_field),
        .cp_opcode2(cp_opcode2),
        .cp_wdata(cp_wdata),
        .cp_rdata(cp_rdata),
        .cp_rvalid(cp_rvalid),
        .cp_undef(cp_undef),
        .dacc_valid(dacc_valid),
        .dacc_size(dacc_size),
        .dacc_addr_lo(dacc_addr_lo),
        .align_fault(align_fault),
        .vector_base(vector_base),
        .icache_en(icache_en),
        .dcache_en(dcache_en),
        .wbuf_en(wbuf_en),
        .rom_prot(rom_prot),
        .sys_prot(sys_prot),
        .align_chk_en(align_chk_en),
        .mmu_en(mmu_en),
        .icache_present(icache_present),
        .icache_line_bytes(icache_line_bytes),
        .icache_size_bytes(icache_size_bytes),
        .icache_ways(icache_ways)
    );

    scr_core_model core (
        .clk(clk),
        .cp_valid(cp_valid),
        .cp_write(cp_write),
        .cp_reg(cp_reg),
        .secondary_register_field(secondary_register_field),
        .cp_opcode2(cp_opcode2),
        .cp_wdata(cp_wdata),
        .cp_rdata(cp_rdata),
        .cp_rvalid(cp_rvalid),
        .cp_undef(cp_undef)
    );

    // ------------------------------------------------------------
    // Checking and reporting
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            n_tests++;
            if (seen !== exp)
            begin
                fails++;
                $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task automatic give_verdict;
        begin
            $display("Comparisons %0d, mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    task automatic rd(input logic [3:0] rn, input scr_pkg::scr_word_t exp,
        input logic exp_undef);
        scr_pkg::scr_word_t d;
        logic ok;
        logic und;
        begin
            core.read(rn, d, ok, und);
            check({31'h0, ok}, 32'h00000001);
            check({31'h0, und}, {31'h0, exp_undef});
            check(d, exp);
        end
    endtask

    task automatic do_reset(input logic pin);
        begin
            sys_rst = 1'b1;
            high_vectors_pin = pin;
            repeat (10) @(negedge clk);
            sys_rst = 1'b0;
        end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // A hung run still reaches the verdict.
    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        dacc_valid = 1'b0;
        dacc_size = scr_pkg::SCR_BYTE;
        dacc_addr_lo = 2'h0;
        do_reset(1'b1);
        check(vector_base, 32'hFFFF0000);
        rd(4'h1, 32'h00002070, 1'b0);
        rd(4'h0, 32'h0000008D, 1'b0);
        check({16'h0, icache_present, icache_line_bytes, icache_ways},
            {16'h0, 1'b1, 7'h10, 8'h03});
        check({15'h0, icache_size_bytes}, 32'h00000C00);
        core.write(4'h0, 32'h00003307);
        rd(4'h0, 32'h0000008D, 1'b0);
        rd(4'h1, 32'h00002070, 1'b0);
        rd(4'h2, 32'h00000000, 1'b1);
        foreach (rows[i])
        begin
            core.write(4'h1, rows[i].wr);
            check({25'h0, icache_en, rom_prot, sys_prot, align_chk_en, mmu_en,
                dcache_en, wbuf_en}, {25'h0, rows[i].en[6:0]});
            check(vector_base, rows[i].en[7] ? 32'hFFFF0000 : 32'h0);
            rd(4'h1, rows[i].rd, 1'b0);
        end
        core.rmw(32'h0000000D, 32'h00000000);
        check({29'h0, mmu_en, dcache_en, wbuf_en}, 32'h00000007);
        rd(4'h1, 32'h0000007D, 1'b0);
        // Every size and offset back to back, one access a cycle.
        core.rmw(32'h00000002, 32'h00000000);
        core.idle();
        for (int i = 0; i < 12; i++)
        begin
            dacc_valid = 1'b1;
            dacc_size = scr_pkg::scr_acc_size_e'(i / 4);
            dacc_addr_lo = 2'(i % 4);
            exp_f = (i / 4 == 1) ? dacc_addr_lo[0] :
                ((i / 4 == 2) && (dacc_addr_lo != 2'h0));
            @(negedge clk);
            check({31'h0, align_fault}, {31'h0, exp_f});
        end
        dacc_valid = 1'b0;
        core.rmw(32'h00000000, 32'h00000002);
        core.idle();
        dacc_valid = 1'b1;
        dacc_size = scr_pkg::SCR_WORD;
        dacc_addr_lo = 2'h2;
        @(negedge clk);
        dacc_valid = 1'b0;
        check({31'h0, align_fault}, 32'h00000000);
        do_reset(1'b0);
        check(vector_base, 32'h00000000);
        high_vectors_pin = 1'b1;
        rd(4'h1, 32'h00000070, 1'b0);
        core.idle();
        give_verdict();
    end
endmodule
